// File: pkg/sfbp_pkg.sv
package sfbp_pkg;
   localparam int          LANE_W        = 32;
   localparam int          BYTE_W        = 8;
   localparam int          WORD_BYTES    = 4;
   localparam int          CNT_W         = 10;
   localparam int          F_DEFAULT     = 8;
   localparam int          K_DEFAULT     = 4;
   localparam int          LANES_DEFAULT = 4;
   localparam logic [3:0]  POS_NONE      = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
   localparam logic [CNT_W:0]   CNT_STEP = 11'h004;
   localparam logic        RST_ASSERTED  = 1'b0;
   localparam logic        PIN_IDLE      = 1'b0;

   typedef logic [3:0] sfbp_pos_t;

   typedef struct packed {
      sfbp_pos_t frame;
      sfbp_pos_t multi;
   } sfbp_bound_t;

   typedef enum logic [0:0] {
      LINK_SYNC = 1'b0,
      LINK_DATA = 1'b1
   } sfbp_link_t;
endpackage

// File: test/sfbp_far_model.sv
`timescale 1ns/1ps
module sfbp_far_model
#(
   parameter int W = 128
)
(
   input  wire logic                sys_clk,
   input  wire logic                aligned,
   input  wire logic                kick,
   input  wire logic                send,
   input  wire logic [W-1:0]        word,
   input  wire sfbp_pkg::sfbp_pos_t pos,
   output      logic                txSysref,
   output      logic                txSyncReq_b,
   output      logic [W-1:0]        rxLaneData,
   output      sfbp_pkg::sfbp_pos_t rxLaneFramePos
);
   import sfbp_pkg::*;
   logic [W-1:0] last;
   assign txSyncReq_b = aligned;
   assign txSysref = kick;
   always_ff @(posedge sys_clk)
   begin
      if (send)
         last <= word;
   end
   // idle bus shows inverted stale data
   assign rxLaneData = send ? word : ~last;
   assign rxLaneFramePos = send ? pos : POS_NONE;
endmodule

// File: test/tb_sfbp_link_ports.sv
`timescale 1ns/1ps
module tb_sfbp_link_ports;
   import sfbp_pkg::*;
   logic          sys_clk = 0;
   logic          rst_b = 0;
   logic          cfgSubclass1 = 0;
   logic          aligned = 0;
   logic          kick = 0;
   logic          send = 0;
   logic          rxLinkUp = 0;
   logic [127:0]  word = '0;
   sfbp_pos_t     pos = '0;
   logic          txSysref;
   logic          txSyncReq_b;
   logic [127:0]  rxLaneData;
   sfbp_pos_t     rxLaneFramePos;
   sfbp_pos_t     txFrameFirstBytePos;
   sfbp_pos_t     txMultiframeFirstBytePos;
   logic          txSyncRequest;
   logic [127:0]  rxTdata;
   logic          rxTvalid;
   sfbp_pos_t     rxFrameFirstBytePos;
   logic          rxStreamRst_b;
   int            n_fail = 0;
   int            cmp_count = 0;
   sfbp_far_model far (.sys_clk, .aligned, .kick, .send, .word, .pos,
      .txSysref, .txSyncReq_b, .rxLaneData, .rxLaneFramePos);
   sfbp_link_ports #(.LANES(4)) DUT (.sys_clk, .rst_b, .cfgSubclass1,
      .txSysref, .txSyncReq_b, .txFrameFirstBytePos,
      .txMultiframeFirstBytePos, .txSyncRequest, .rxLaneData,
      .rxLaneValid(send), .rxLaneFramePos, .rxLinkUp, .rxTdata, .rxTvalid,
      .rxFrameFirstBytePos, .rxStreamRst_b);
   initial
   begin
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic check(logic [128:0] got, logic [128:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      if (n_fail == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // find a multiframe start, then follow F=8, K=4 cadence
   task automatic walk;
      int i;
      i = 0;
      while (txMultiframeFirstBytePos !== 4'h1 && i < 12)
      begin
         tick(1);
         i++;
      end
      for (i = 0; i < 16; i++)
      begin
         check({txFrameFirstBytePos, txMultiframeFirstBytePos},
            {(i % 2 == 0) ? 4'h1 : 4'h0, (i % 8 == 0) ? 4'h1 : 4'h0});
         tick(1);
      end
   endtask
   task automatic sysref_pulse(logic sub1, sfbp_pos_t expMulti);
      cfgSubclass1 = sub1;
      kick = 1;
      tick(1);
      kick = 0;
      tick(2);
      check({txFrameFirstBytePos, txMultiframeFirstBytePos},
         {expMulti, expMulti});
   endtask
   task automatic sync_up;
      tick(1);
      check({txSyncRequest, rxTvalid, rxStreamRst_b}, 3'h4);
      tick(3);
      rst_b = 1;
      tick(6);
      check(txSyncRequest, 1'b1);
      aligned = 1;
      tick(8);
      check(txSyncRequest, 1'b0);
   endtask
   task automatic rx_word(logic [127:0] w, sfbp_pos_t p, logic up);
      rxLinkUp = up;
      word = w;
      pos = p;
      send = 1;
      tick(1);
      send = 0;
      check(rxFrameFirstBytePos, up ? p : POS_NONE);
      check(rxStreamRst_b, up);
      tick(1);
      check({rxTvalid, rxTdata}, {up, w});
   endtask
   initial
   begin
      repeat (2000) @(posedge sys_clk);
      n_fail++;
      give_verdict();
   end
   initial
   begin
      sync_up();
      walk();
      sysref_pulse(1'b0, 4'h0);
      tick(1);
      sysref_pulse(1'b1, 4'h1);
      walk();
      for (int k = 0; k < 5; k++)
         rx_word({16{8'(k)}} ^ {32'h33323130, 32'h23222120,
            32'h13121110, 32'h03020100}, (k == 4) ? 4'hF : 4'(1 << k),
            1'b1);
      rx_word({4{32'hA5C3F00F}}, 4'h1, 1'b0);
      give_verdict();
   end
endmodule

// File: verilog/sfbp_link_ports.sv
`timescale 1ns/1ps
// What this block does
// - tx multiframe boundary is four bits, one flag per byte like frame start.
// - in subclass 1 the sysref input realigns the transmit boundary counters.
// - sync input is active low; low means sync request, high means data.
// - frame and multiframe boundary flags are four bits, one per byte.
// - one boundary indication applies to every lane's 32-bit slice.
// - all receive streaming signals are synchronous to the core clock.
// - receiver drives one active-low stream reset common to all lanes.
// - receive bus is 32 bits per lane, lane 0 on the lowest bits.
// - the least significant byte of each lane word arrived first.
// - a valid flag marks cycles carrying valid receive data.
// - receive frame start uses the same byte-position encoding as transmit.
// - receive frame start is asserted one cycle before its data word.
// - with multiframe and buffer delay multiples of 4, first byte is byte 0.
// - bit n set means frame starts in byte n; several bits allowed.
// - tx frame start describes the word accepted in the next cycle.
module sfbp_link_ports
#(
   parameter int LANES         = sfbp_pkg::LANES_DEFAULT,
   parameter int FRAME_OCTETS  = sfbp_pkg::F_DEFAULT,
   parameter int FRAMES_PER_MF = sfbp_pkg::K_DEFAULT
)
(
   input  wire logic                               sys_clk,
   input  wire logic                               rst_b,
   input  wire logic                               cfgSubclass1,
   input  wire logic                               txSysref,
   input  wire logic                               txSyncReq_b,
   output      sfbp_pkg::sfbp_pos_t                txFrameFirstBytePos,
   output      sfbp_pkg::sfbp_pos_t                txMultiframeFirstBytePos,
   output      logic                               txSyncRequest,
   input  wire logic [LANES*sfbp_pkg::LANE_W-1:0]  rxLaneData,
   input  wire logic                               rxLaneValid,
   input  wire sfbp_pkg::sfbp_pos_t                rxLaneFramePos,
   input  wire logic                               rxLinkUp,
   output      logic [LANES*sfbp_pkg::LANE_W-1:0]  rxTdata,
   output      logic                               rxTvalid,
   output      sfbp_pkg::sfbp_pos_t                rxFrameFirstBytePos,
   output      logic                               rxStreamRst_b
);
   import sfbp_pkg::*;

   localparam int            BUS_W   = LANES * LANE_W;
   localparam logic [CNT_W-1:0] FR_LEN =
      CNT_W'(FRAME_OCTETS);
   localparam logic [CNT_W-1:0] MF_LEN =
      CNT_W'(FRAME_OCTETS * FRAMES_PER_MF);

   typedef struct packed {
      logic              syncMeta;
      logic              syncReq_b;
      logic              sysrefMeta;
      logic              sysref;
      logic              sysrefPrev;
      sfbp_link_t        link;
      logic              syncReqOut;
      logic [CNT_W-1:0]  frCnt;
      logic [CNT_W-1:0]  mfCnt;
      sfbp_bound_t       txBound;
      logic [BUS_W-1:0]  rxHoldData;
      logic              rxHoldValid;
      logic [BUS_W-1:0]  rxData;
      logic              rxValid;
      sfbp_pos_t         rxPos;
      logic              rxRst_b;
   } sfbp_state_t;

   sfbp_state_t st;
   sfbp_state_t next_st;

   // reduce a count that may exceed the length by up to four lengths
   function automatic logic [CNT_W-1:0] wrapCnt(
      input logic [CNT_W:0]   s,
      input logic [CNT_W-1:0] len
   );
      logic [CNT_W:0] r;
      r = s;
      for (int i = 0; i < WORD_BYTES; i++)
      begin
         if (r >= {1'b0, len})
         begin
            r = r - {1'b0, len};
         end
      end
      return r[CNT_W-1:0];
   endfunction

   // one flag per byte lane: set where a new frame or multiframe begins
   function automatic sfbp_pos_t posFlags(
      input logic [CNT_W-1:0] c,
      input logic [CNT_W-1:0] len
   );
      sfbp_pos_t f;
      f = POS_NONE;
      for (int b = 0; b < WORD_BYTES; b++)
      begin
         f[b] = (wrapCnt({1'b0, c} + (CNT_W+1)'(b), len) == CNT_ZERO);
      end
      return f;
   endfunction

   logic             sysrefEdge;
   logic             realign;
   logic [CNT_W-1:0] wordFr;
   logic [CNT_W-1:0] wordMf;

   always_comb
   begin
      next_st = st;
      next_st.syncMeta   = txSyncReq_b;
      next_st.syncReq_b  = st.syncMeta;
      next_st.sysrefMeta = txSysref;
      next_st.sysref     = st.sysrefMeta;
      next_st.sysrefPrev = st.sysref;

      sysrefEdge = st.sysref & ~st.sysrefPrev;
      // subclass 1 anchors the boundaries on sysref, else on sync release
      realign = cfgSubclass1 ? sysrefEdge : ~st.syncReq_b;
      next_st.link = st.syncReq_b ? LINK_DATA : LINK_SYNC;
      next_st.syncReqOut = (next_st.link == LINK_SYNC);

      // counters and flags describe the word taken in the next cycle
      wordFr = realign ? CNT_ZERO : wrapCnt({1'b0, st.frCnt} + CNT_STEP,
                                            FR_LEN);
      wordMf = realign ? CNT_ZERO : wrapCnt({1'b0, st.mfCnt} + CNT_STEP,
                                            MF_LEN);
      next_st.frCnt = wordFr;
      next_st.mfCnt = wordMf;
      // a single flag set is shared by all lane slices
      next_st.txBound.frame = posFlags(wordFr, FR_LEN);
      next_st.txBound.multi = posFlags(wordMf, MF_LEN);

      // boundary flags leave one stage ahead of the matching data word
      next_st.rxPos       = (rxLaneValid & rxLinkUp) ? rxLaneFramePos
                                                     : POS_NONE;
      next_st.rxHoldData  = rxLaneData;
      next_st.rxHoldValid = rxLaneValid & rxLinkUp;
      next_st.rxData      = st.rxHoldData;
      next_st.rxValid     = st.rxHoldValid;
      next_st.rxRst_b     = rxLinkUp;
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st         <= '0;
         st.link    <= LINK_SYNC;
         st.rxRst_b <= RST_ASSERTED;
         st.syncMeta  <= PIN_IDLE;
         st.syncReq_b <= PIN_IDLE;
         st.syncReqOut <= ~PIN_IDLE;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign txFrameFirstBytePos      = st.txBound.frame;
   assign txMultiframeFirstBytePos = st.txBound.multi;
   assign txSyncRequest            = st.syncReqOut;
   assign rxTdata                  = st.rxData;
   assign rxTvalid                 = st.rxValid;
   assign rxFrameFirstBytePos      = st.rxPos;
   assign rxStreamRst_b            = st.rxRst_b;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   AST_TX_MF_IN_FRAME: assert property (
      (txMultiframeFirstBytePos & ~txFrameFirstBytePos) == POS_NONE)
      else $error("multiframe start outside a frame start");

   AST_TX_SYSREF_ALIGN: assert property (
      (cfgSubclass1 && st.sysref && !st.sysrefPrev)
      |=> txMultiframeFirstBytePos[0] && txFrameFirstBytePos[0])
      else $error("sysref edge did not realign boundaries");

   AST_TX_SYNC_REQ: assert property (
      (!st.syncReq_b && !cfgSubclass1)
      |=> txSyncRequest && txMultiframeFirstBytePos[0])
      else $error("sync request not honoured");

   AST_TX_SYNC_DROP: assert property (
      $rose(st.syncReq_b) |=> !txSyncRequest)
      else $error("sync request kept after sync input rose");

   AST_TX_FRAME_ONEHOT: assert property (
      (FRAME_OCTETS >= WORD_BYTES) |-> $onehot0(txFrameFirstBytePos))
      else $error("frame start has several bits for large frames");

   AST_RX_RESET: assert property (
      !rxLinkUp |=> !rxStreamRst_b)
      else $error("stream reset not asserted while link down");

   AST_RX_VALID: assert property (
      (rxLaneValid && rxLinkUp) |-> ##2 rxTvalid)
      else $error("valid word not flagged two cycles later");

   AST_RX_DATA: assert property (
      (rxLaneValid && rxLinkUp) |-> ##2 (rxTdata == $past(rxLaneData, 2)))
      else $error("receive data lost its lane order");

   AST_RX_POS_LEADS: assert property (
      (rxFrameFirstBytePos != POS_NONE) |=> rxTvalid)
      else $error("frame start not one cycle ahead of data");

   AST_RX_POS_IDLE: assert property (
      !rxStreamRst_b |-> (rxFrameFirstBytePos == POS_NONE))
      else $error("frame start flagged during stream reset");

   COV_RX_STREAM: cover property (
      rxFrameFirstBytePos[0] ##1 rxTvalid ##1 rxTvalid);
   COV_TX_SYSREF: cover property (
      cfgSubclass1 && st.sysref && !st.sysrefPrev);
   COV_TX_SYNC_RELEASE: cover property (
      txSyncRequest ##1 !txSyncRequest);
   COV_TX_LINK_DATA: cover property (
      st.link == LINK_DATA && txMultiframeFirstBytePos[0]);
endmodule
